// File: tca_pkg.sv
// Shared constants, register map, operation codes and states of the tiny core execution datapath.
package tca_pkg;

	// Register byte offsets on the Wishbone bus.
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_DEST   = 8'h04;
	localparam logic [7:0] REG_SRC    = 8'h08;
	localparam logic [7:0] REG_IMM    = 8'h0c;
	localparam logic [7:0] REG_WORD   = 8'h10;
	localparam logic [7:0] REG_ZPTR   = 8'h14;
	localparam logic [7:0] REG_PC     = 8'h18;
	localparam logic [7:0] REG_FLAGS  = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_STKPTR = 8'h24;
	localparam logic [7:0] REG_RETADR = 8'h28;

	// Command field and status bits.
	localparam int         CMD_OP_W   = 5;
	localparam int         ST_BUSY    = 0;
	localparam int         IMM_W      = 12;

	// Status flag bit positions in the flag register.
	localparam int         FL_C       = 0;
	localparam int         FL_Z       = 1;
	localparam int         FL_N       = 2;
	localparam int         FL_V       = 3;
	localparam int         FL_S       = 4;
	localparam int         FL_H       = 5;

	// Which flags each operation class updates.
	localparam logic [7:0] MASK_ARITH = 8'h2f;
	localparam logic [7:0] MASK_WORD  = 8'h1f;
	localparam logic [7:0] MASK_LOGIC = 8'h0e;
	localparam logic [7:0] MASK_INV   = 8'h0f;
	localparam logic [7:0] MASK_NONE  = 8'h00;

	// Reset value of the flags and shared byte constants.
	localparam logic [7:0] FLAGS_RST  = 8'h00;
	localparam logic [7:0] BYTE_ONES  = 8'hff;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam logic [7:0] BYTE_ONE   = 8'h01;
	localparam logic [7:0] WORD_K_MSK = 8'h3f;

	// Execution lengths in clock cycles and return stack step.
	localparam logic [1:0] CYC_SINGLE = 2'h1;
	localparam logic [1:0] CYC_WORD   = 2'h2;
	localparam logic [1:0] CYC_RJUMP  = 2'h2;
	localparam logic [1:0] CYC_ZJUMP  = 2'h2;
	localparam logic [1:0] CYC_ZCALL  = 2'h3;
	localparam int         RET_STEP   = 2;

	// Operation codes written to the command register.
	localparam logic [4:0] OP_ADD                  = 5'h00;
	localparam logic [4:0] OP_ADD_CARRY            = 5'h01;
	localparam logic [4:0] OP_WORD_IMMEDIATE_PLUS  = 5'h02;
	localparam logic [4:0] OP_SUB                  = 5'h03;
	localparam logic [4:0] OP_DIFFERENCE_CONST     = 5'h04;
	localparam logic [4:0] OP_BORROW_DIFF_REGS     = 5'h05;
	localparam logic [4:0] OP_BORROW_DIFF_CONST    = 5'h06;
	localparam logic [4:0] OP_WORD_IMMEDIATE_MINUS = 5'h07;
	localparam logic [4:0] OP_AND_REGS             = 5'h08;
	localparam logic [4:0] OP_BITWISE_CONJ_CONST   = 5'h09;
	localparam logic [4:0] OP_OR_REGS              = 5'h0a;
	localparam logic [4:0] OP_BITWISE_DISJ_CONST   = 5'h0b;
	localparam logic [4:0] OP_EXCLUSIVE_DISJ_REGS  = 5'h0c;
	localparam logic [4:0] OP_ONES_INVERT          = 5'h0d;
	localparam logic [4:0] OP_TWOS_INVERSE         = 5'h0e;
	localparam logic [4:0] OP_BITS_SET_MASK        = 5'h0f;
	localparam logic [4:0] OP_BITS_CLEAR_MASK      = 5'h10;
	localparam logic [4:0] OP_PLUS_ONE             = 5'h11;
	localparam logic [4:0] OP_MINUS_ONE            = 5'h12;
	localparam logic [4:0] OP_ZERO_SIGN_CHECK      = 5'h13;
	localparam logic [4:0] OP_ZERO_REGISTER        = 5'h14;
	localparam logic [4:0] OP_ONES_REGISTER        = 5'h15;
	localparam logic [4:0] OP_RELATIVE_JUMP        = 5'h16;
	localparam logic [4:0] OP_Z_POINTER_JUMP       = 5'h17;
	localparam logic [4:0] OP_Z_POINTER_CALL       = 5'h18;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_RUN
	} tca_state_t;

endpackage : tca_pkg

// File: tca_alu_jumps.sv
// Execution datapath with arithmetic, logic and jump operations behind a Wishbone slave.
`timescale 1ns/1ps

// Behaviour
// RL1: Register add, with optional carry in, one cycle, updates Z C N V H.
// RL2: Word add of a constant to a register pair, two cycles, updates Z C N V S.
// RL3: Subtract register or constant, one cycle, updates Z C N V H.
// RL4: Subtract register or constant plus carry, one cycle, updates Z C N V H.
// RL5: Word subtract of a constant, two cycles, updates Z C N V S.
// RL6: Bitwise and with register or constant, one cycle, updates Z N V.
// RL7: Bitwise or and exclusive or, one cycle, Z N V; self exclusive or clears.
// RL8: Ones complement is ff minus value; twos complement is zero minus value, adds H.
// RL9: Set bits by or, clear bits by and with inverted mask; all ones keeps flags.
// RL10: Increment or decrement by one in one cycle, Z N V, carry kept.
// RL11: Test value by anding with itself in one cycle, updates Z N V.
// RL12: Relative jump loads counter plus offset plus one, two cycles, no flags.
// RL13: Pointer jump loads counter from Z pair, flags unchanged.
// RL14: Pointer call pushes return address, loads counter from Z, flags unchanged.
// RL15: Flags are zero, negative, overflow, carry out of bit 7, half carry of bit 3.
// RL16: Word operations use low and next higher byte, both written after second cycle.
module tca_alu_jumps #(
	parameter int              PC_W    = 16,
	parameter logic [15:0]     SP_INIT = 16'hffff
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	output logic               busy_o
);

	if (PC_W < tca_pkg::IMM_W || PC_W > 16) begin : g_pc_w_check
		$error("PC_W must lie between the offset width and 16");
	end

	// Returns {half carry, overflow, carry, result} of an 8-bit add or subtract.
	function automatic logic [10:0] addsub8(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic sub);
		logic [8:0] s;
		logic       h;
		logic       v;
		s = 9'h000;
		if (sub) begin
			s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			h = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
			v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
		end else begin
			s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			h = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
			v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
		end
		return {h, v, s[8], s[7:0]};
	endfunction : addsub8

	// Merges a byte-enabled write into a 16-bit register.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	tca_pkg::tca_state_t   state_r;
	logic [4:0]            op_r;
	logic [1:0]            cnt_r;
	logic [7:0]            dest_r;
	logic [7:0]            src_r;
	logic [tca_pkg::IMM_W-1:0] imm_r;
	logic [15:0]           word_r;
	logic [15:0]           zptr_r;
	logic [PC_W-1:0]       pc_r;
	logic [7:0]            flags_r;
	logic [15:0]           sp_r;
	logic [PC_W-1:0]       ret_r;
	logic [7:0]            wlo_r;
	logic                  wcarry_r;
	logic [31:0]           rdat_nxt;
	logic [7:0]            res_nxt;
	logic [7:0]            fl_nxt;
	logic [7:0]            fmask_nxt;
	logic                  dest_we;
	logic [1:0]            cyc_nxt;

	// Bus decode.
	wire                   bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire                   bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
	wire                   hit_cmd   = wb_adr_i == tca_pkg::REG_CMD;
	wire                   hit_dest  = wb_adr_i == tca_pkg::REG_DEST;
	wire                   hit_src   = wb_adr_i == tca_pkg::REG_SRC;
	wire                   hit_imm   = wb_adr_i == tca_pkg::REG_IMM;
	wire                   hit_word  = wb_adr_i == tca_pkg::REG_WORD;
	wire                   hit_zptr  = wb_adr_i == tca_pkg::REG_ZPTR;
	wire                   hit_pc    = wb_adr_i == tca_pkg::REG_PC;
	wire                   hit_flags = wb_adr_i == tca_pkg::REG_FLAGS;
	wire                   hit_sp    = wb_adr_i == tca_pkg::REG_STKPTR;
	wire                   idle      = state_r == tca_pkg::ST_IDLE;
	wire                   start     = bus_wr & hit_cmd & idle;
	wire                   host_wr   = bus_wr & idle;
	wire                   last      = (state_r == tca_pkg::ST_RUN) && (cnt_r == 2'h1);
	wire [7:0]             k_word    = imm_r[7:0] & tca_pkg::WORD_K_MSK;
	wire [PC_W-1:0]        rel_off   = PC_W'($signed(imm_r));
	wire [PC_W-1:0]        pc_seq    = pc_r + PC_W'(1);
	wire [PC_W-1:0]        pc_rel    = pc_seq + rel_off;
	wire [PC_W-1:0]        pc_z      = zptr_r[PC_W-1:0];
	wire [7:0]             k8        = imm_r[7:0];
	wire                   is_wsub   = op_r == tca_pkg::OP_WORD_IMMEDIATE_MINUS;
	wire [10:0]            wlo_sum   = addsub8(word_r[7:0], k_word, 1'b0, is_wsub);
	wire [10:0]            whi_sum   = addsub8(word_r[15:8], tca_pkg::BYTE_ZERO, wcarry_r,
		is_wsub);
	wire [15:0]            wres      = {whi_sum[7:0], wlo_r};
	wire                   w_c       = is_wsub ? (wres[15] & ~word_r[15])
		: (~wres[15] & word_r[15]);
	wire                   w_v       = is_wsub ? (word_r[15] & ~wres[15])
		: (~word_r[15] & wres[15]);
	wire [7:0]             fl_word   = {3'h0, wres[15] ^ w_v, w_v, wres[15],
		wres == 16'h0000, w_c};
	wire [7:0]             flags_upd = (flags_r & ~fmask_nxt) | (fl_nxt & fmask_nxt);
	wire [15:0]            imm_wr    = merge16(16'(imm_r), wb_dat_i, wb_sel_i);
	wire [15:0]            pc_wr     = merge16(16'(pc_r), wb_dat_i, wb_sel_i);

	// Cycle count of the command being started.
	wire [4:0]             cmd_op    = wb_dat_i[tca_pkg::CMD_OP_W-1:0];
	assign cyc_nxt = (cmd_op == tca_pkg::OP_WORD_IMMEDIATE_PLUS
		|| cmd_op == tca_pkg::OP_WORD_IMMEDIATE_MINUS) ? tca_pkg::CYC_WORD :
		(cmd_op == tca_pkg::OP_RELATIVE_JUMP) ? tca_pkg::CYC_RJUMP :
		(cmd_op == tca_pkg::OP_Z_POINTER_JUMP) ? tca_pkg::CYC_ZJUMP :
		(cmd_op == tca_pkg::OP_Z_POINTER_CALL) ? tca_pkg::CYC_ZCALL :
		tca_pkg::CYC_SINGLE;

	// Byte result and flags of the single-cycle operations.
	always_comb begin
		logic [10:0] r;
		r = 11'h000;
		res_nxt = dest_r;
		fl_nxt = 8'h00;
		fmask_nxt = tca_pkg::MASK_NONE;
		dest_we = 1'b1;
		case (op_r)
			tca_pkg::OP_ADD, tca_pkg::OP_ADD_CARRY: begin
				r = addsub8(dest_r, src_r, (op_r == tca_pkg::OP_ADD_CARRY) & flags_r[tca_pkg::FL_C],
					1'b0); // RL1
				fmask_nxt = tca_pkg::MASK_ARITH;
			end
			tca_pkg::OP_SUB, tca_pkg::OP_DIFFERENCE_CONST: begin
				r = addsub8(dest_r, (op_r == tca_pkg::OP_SUB) ? src_r : k8, 1'b0, 1'b1); // RL3
				fmask_nxt = tca_pkg::MASK_ARITH;
			end
			tca_pkg::OP_BORROW_DIFF_REGS, tca_pkg::OP_BORROW_DIFF_CONST: begin
				r = addsub8(dest_r, (op_r == tca_pkg::OP_BORROW_DIFF_REGS) ? src_r : k8,
					flags_r[tca_pkg::FL_C], 1'b1); // RL4
				fmask_nxt = tca_pkg::MASK_ARITH;
			end
			tca_pkg::OP_AND_REGS: begin
				r = {3'h0, dest_r & src_r}; // RL6
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			tca_pkg::OP_BITWISE_CONJ_CONST: begin
				r = {3'h0, dest_r & k8}; // RL6
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			tca_pkg::OP_OR_REGS: begin
				r = {3'h0, dest_r | src_r}; // RL7
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			tca_pkg::OP_BITWISE_DISJ_CONST, tca_pkg::OP_BITS_SET_MASK: begin
				r = {3'h0, dest_r | k8}; // RL7 RL9
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			tca_pkg::OP_EXCLUSIVE_DISJ_REGS: begin
				r = {3'h0, dest_r ^ src_r}; // RL7
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			tca_pkg::OP_ZERO_REGISTER: begin
				r = {3'h0, dest_r ^ dest_r}; // RL7
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			tca_pkg::OP_ONES_INVERT: begin
				r = {3'h1, tca_pkg::BYTE_ONES - dest_r}; // RL8
				fmask_nxt = tca_pkg::MASK_INV;
			end
			tca_pkg::OP_TWOS_INVERSE: begin
				r = addsub8(tca_pkg::BYTE_ZERO, dest_r, 1'b0, 1'b1); // RL8
				fmask_nxt = tca_pkg::MASK_ARITH;
			end
			tca_pkg::OP_BITS_CLEAR_MASK: begin
				r = {3'h0, dest_r & (tca_pkg::BYTE_ONES - k8)}; // RL9
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			tca_pkg::OP_ONES_REGISTER: begin
				r = {3'h0, tca_pkg::BYTE_ONES}; // RL9
			end
			tca_pkg::OP_PLUS_ONE, tca_pkg::OP_MINUS_ONE: begin
				r = addsub8(dest_r, tca_pkg::BYTE_ONE, 1'b0, op_r == tca_pkg::OP_MINUS_ONE); // RL10
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			tca_pkg::OP_ZERO_SIGN_CHECK: begin
				r = {3'h0, dest_r & dest_r}; // RL11
				fmask_nxt = tca_pkg::MASK_LOGIC;
			end
			default: begin
				r = {3'h0, dest_r};
				dest_we = 1'b0;
			end
		endcase
		res_nxt = r[7:0];
		fl_nxt[tca_pkg::FL_Z] = (r[7:0] == tca_pkg::BYTE_ZERO); // RL15
		if (op_r == tca_pkg::OP_BORROW_DIFF_REGS || op_r == tca_pkg::OP_BORROW_DIFF_CONST) begin
			fl_nxt[tca_pkg::FL_Z] = (r[7:0] == tca_pkg::BYTE_ZERO) & flags_r[tca_pkg::FL_Z];
		end
		fl_nxt[tca_pkg::FL_N] = r[7]; // RL15
		fl_nxt[tca_pkg::FL_C] = r[8];
		fl_nxt[tca_pkg::FL_V] = r[9];
		fl_nxt[tca_pkg::FL_H] = r[10];
	end

	// Read data selection.
	assign rdat_nxt = hit_cmd ? {27'h0, op_r}
		: hit_dest ? {24'h0, dest_r}
		: hit_src ? {24'h0, src_r}
		: hit_imm ? {20'h0, imm_r}
		: hit_word ? {16'h0, word_r}
		: hit_zptr ? {16'h0, zptr_r}
		: hit_pc ? 32'(pc_r)
		: hit_flags ? {24'h0, flags_r}
		: (wb_adr_i == tca_pkg::REG_STATUS) ? (32'(!idle) << tca_pkg::ST_BUSY)
		: hit_sp ? {16'h0, sp_r}
		: (wb_adr_i == tca_pkg::REG_RETADR) ? 32'(ret_r)
		: 32'h0000_0000;

	// Wishbone answer: one ack per request, dropped in the following cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rdat_nxt : 32'h0000_0000;
		end
	end

	// Sequencer.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= tca_pkg::ST_IDLE;
			op_r    <= tca_pkg::OP_ADD;
			cnt_r   <= 2'h0;
			busy_o  <= 1'b0;
		end else if (start) begin
			state_r <= tca_pkg::ST_RUN;
			op_r    <= cmd_op;
			cnt_r   <= cyc_nxt;
			busy_o  <= 1'b1;
		end else if (state_r == tca_pkg::ST_RUN) begin
			cnt_r   <= cnt_r - 2'h1;
			if (last) begin
				state_r <= tca_pkg::ST_IDLE;
				busy_o  <= 1'b0;
			end
		end
	end

	// Operand registers, written by software when idle and by the datapath on completion.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dest_r <= tca_pkg::BYTE_ZERO;
			src_r  <= tca_pkg::BYTE_ZERO;
			imm_r  <= '0;
			word_r <= 16'h0000;
			zptr_r <= 16'h0000;
		end else begin
			if (last && dest_we) begin
				dest_r <= res_nxt;
			end else if (host_wr && hit_dest) begin
				dest_r <= wb_dat_i[7:0];
			end
			if (host_wr && hit_src) begin
				src_r <= wb_dat_i[7:0];
			end
			if (host_wr && hit_imm) begin
				imm_r <= imm_wr[tca_pkg::IMM_W-1:0];
			end
			if (last && (op_r == tca_pkg::OP_WORD_IMMEDIATE_PLUS || is_wsub)) begin
				word_r <= wres; // RL2 RL5 RL16
			end else if (host_wr && hit_word) begin
				word_r <= merge16(word_r, wb_dat_i, wb_sel_i);
			end
			if (host_wr && hit_zptr) begin
				zptr_r <= merge16(zptr_r, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Word operations: low byte in the first cycle, high byte and write-back in the second.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wlo_r    <= tca_pkg::BYTE_ZERO;
			wcarry_r <= 1'b0;
		end else if (state_r == tca_pkg::ST_RUN && cnt_r == tca_pkg::CYC_WORD) begin
			wlo_r    <= wlo_sum[7:0]; // RL16
			wcarry_r <= wlo_sum[8];
		end
	end

	// Flags, program counter and return stack.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r <= tca_pkg::FLAGS_RST;
			pc_r    <= '0;
			sp_r    <= SP_INIT;
			ret_r   <= '0;
		end else begin
			if (last && (op_r == tca_pkg::OP_WORD_IMMEDIATE_PLUS || is_wsub)) begin
				flags_r <= (flags_r & ~tca_pkg::MASK_WORD) | (fl_word & tca_pkg::MASK_WORD); // RL2 RL5
			end else if (last) begin
				flags_r <= flags_upd; // RL15
			end else if (host_wr && hit_flags) begin
				flags_r <= wb_dat_i[7:0];
			end
			if (last && op_r == tca_pkg::OP_RELATIVE_JUMP) begin
				pc_r <= pc_rel; // RL12
			end else if (last && op_r == tca_pkg::OP_Z_POINTER_JUMP) begin
				pc_r <= pc_z; // RL13
			end else if (last && op_r == tca_pkg::OP_Z_POINTER_CALL) begin
				pc_r  <= pc_z; // RL14
				ret_r <= pc_seq;
				sp_r  <= sp_r - 16'(tca_pkg::RET_STEP);
			end else if (host_wr && hit_pc) begin
				pc_r <= pc_wr[PC_W-1:0];
			end else if (host_wr && hit_sp) begin
				sp_r <= merge16(sp_r, wb_dat_i, wb_sel_i);
			end
		end
	end

endmodule : tca_alu_jumps

// File: tca_alu_jumps_sva.sv
// Concurrent checks on bus handshake and execution length of the datapath.
`timescale 1ns/1ps
module tca_alu_jumps_sva (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic       take_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic       cmd_w  = take_w & wb_we_i & wb_sel_i[0] & ~busy_o
		& (wb_adr_i == tca_pkg::REG_CMD);
	wire logic [4:0] op_w   = wb_dat_i[4:0];
	wire logic       two_w  = (op_w == tca_pkg::OP_WORD_IMMEDIATE_PLUS)
		| (op_w == tca_pkg::OP_WORD_IMMEDIATE_MINUS) | (op_w == tca_pkg::OP_RELATIVE_JUMP)
		| (op_w == tca_pkg::OP_Z_POINTER_JUMP);
	wire logic       three_w = (op_w == tca_pkg::OP_Z_POINTER_CALL);

	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	a_ack_after_take: assert property (take_w |=> wb_ack_o)
		else $error("no ack one cycle after a request");
	a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
		else $error("ack without a request");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	a_busy_on_cmd: assert property (cmd_w |=> busy_o)
		else $error("command did not raise busy");
	a_byte_one_cycle: assert property (cmd_w && !two_w && !three_w |=> busy_o ##1 !busy_o)
		else $error("byte operation length wrong");
	a_word_two_cycles: assert property (cmd_w && two_w |=> busy_o [*2] ##1 !busy_o)
		else $error("two cycle operation length wrong");
	a_call_three_cycles: assert property (cmd_w && three_w |=> busy_o [*3] ##1 !busy_o)
		else $error("pointer call length wrong");
	a_flags_upper_zero: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i) == tca_pkg::REG_FLAGS |-> wb_dat_o[31:8] == 24'h0)
		else $error("flag read has upper bits set");
endmodule : tca_alu_jumps_sva

bind tca_alu_jumps tca_alu_jumps_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o);

// File: tca_host_model.sv
// Decoder side model issuing classic single Wishbone cycles to the datapath.
`timescale 1ns/1ps
module tca_host_model (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o  = 1'b0,
	output logic             stb_o  = 1'b0,
	output logic             we_o   = 1'b0,
	output logic [7:0]       adr_o  = 8'h00,
	output logic [3:0]       sel_o  = 4'h0,
	output logic [31:0]      dat_o  = 32'h0,
	output logic             hang_o = 1'b0
);
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 40);
		if (ack_i !== 1'b1)
			hang_o <= 1'b1;
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Released data and select lines show the inverse so stale values are never trusted.
		dat_o <= ~d;
		sel_o <= ~s;
	endtask : xfer
endmodule : tca_host_model

// File: tca_alu_jumps_tb.sv
// Self-checking bench for the datapath, driving it through the host model.
`timescale 1ns/1ps
module tca_alu_jumps_tb;
	logic        clk_i;
	logic        rst_i = 1'b1;
	logic        cyc, stb, we, ack, busy, hang;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	int          n_mismatch = 0;
	int          checks     = 0;

	tca_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hang_o(hang));
	tca_alu_jumps #(.PC_W(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic end_sim;
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	always @(posedge hang) begin
		n_mismatch++;
		end_sim();
	end

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
		logic [31:0] q;
		u_host.xfer(1'b1, a, s, d, q);
	endtask : wr

	task automatic rchk(string nm, logic [7:0] a, logic [31:0] exp);
		logic [31:0] q;
		u_host.xfer(1'b0, a, 4'h0, 32'h0, q);
		chk(nm, exp, q);
	endtask : rchk

	// Polls the status word until the command has finished.
	task automatic wait_idle;
		logic [31:0] q;
		int          n;
		n = 0;
		do begin
			u_host.xfer(1'b0, tca_pkg::REG_STATUS, 4'h0, 32'h0, q);
			n++;
		end while (q[tca_pkg::ST_BUSY] !== 1'b0 && n < 20);
		if (q[tca_pkg::ST_BUSY] !== 1'b0) begin
			n_mismatch++;
			end_sim();
		end
	endtask : wait_idle

	task automatic t_reset;
		rchk("flags", tca_pkg::REG_FLAGS, 32'h0);
		rchk("stack", tca_pkg::REG_STKPTR, 32'h0000_ffff);
		rchk("pc", tca_pkg::REG_PC, 32'h0);
		rchk("status", tca_pkg::REG_STATUS, 32'h0);
		wr(8'h30, 32'h0000_00a5);
		rchk("unmapped", 8'h30, 32'h0);
	endtask : t_reset

	// Rows: op, dest, src, const, flags in, dest out, flags out.
	task automatic t_byte;
		logic [55:0] tv [22] = '{
			56'h00_0f_01_00_00_10_20, 56'h01_7f_00_00_01_80_2c, 56'h03_00_01_00_00_ff_25,
			56'h04_80_00_01_00_7f_28, 56'h05_10_0f_00_03_00_22, 56'h06_10_00_0f_01_00_20,
			56'h08_f0_3c_00_01_30_01, 56'h09_80_00_ff_00_80_04, 56'h0a_00_00_00_08_00_02,
			56'h0b_01_00_80_00_81_04, 56'h0c_55_55_00_01_00_03, 56'h0d_00_00_00_00_ff_05,
			56'h0e_01_00_00_00_ff_25, 56'h0f_10_00_01_01_11_01, 56'h10_ff_00_0f_01_f0_05,
			56'h11_7f_00_00_01_80_0d, 56'h12_80_00_00_01_7f_09, 56'h13_00_00_00_09_00_03,
			56'h14_5a_00_00_00_00_02, 56'h15_12_00_00_2a_ff_2a, 56'h1f_12_00_00_15_12_15,
			56'h11_ff_00_00_00_00_02};
		foreach (tv[i]) begin
			wr(tca_pkg::REG_FLAGS, {24'h0, tv[i][23:16]});
			wr(tca_pkg::REG_DEST, {24'h0, tv[i][47:40]});
			wr(tca_pkg::REG_SRC, {24'h0, tv[i][39:32]});
			wr(tca_pkg::REG_IMM, {24'h0, tv[i][31:24]});
			wr(tca_pkg::REG_CMD, {24'h0, tv[i][55:48]});
			wait_idle();
			rchk("dest", tca_pkg::REG_DEST, {24'h0, tv[i][15:8]});
			rchk("flags", tca_pkg::REG_FLAGS, {24'h0, tv[i][7:0]});
		end
	endtask : t_byte

	// Rows: op, word in, const, flags in, word out, flags out.
	task automatic t_word;
		logic [63:0] tv [3] = '{64'h02_ffff_01_20_0000_23, 64'h07_0000_01_00_ffff_15,
			64'h07_8000_01_00_7fff_18};
		foreach (tv[i]) begin
			wr(tca_pkg::REG_FLAGS, {24'h0, tv[i][31:24]});
			wr(tca_pkg::REG_WORD, {16'h0, tv[i][55:40]});
			wr(tca_pkg::REG_IMM, {24'h0, tv[i][39:32]});
			wr(tca_pkg::REG_CMD, {24'h0, tv[i][63:56]});
			wait_idle();
			rchk("word", tca_pkg::REG_WORD, {16'h0, tv[i][23:8]});
			rchk("wflags", tca_pkg::REG_FLAGS, {24'h0, tv[i][7:0]});
		end
	endtask : t_word

	task automatic t_jump;
		wr(tca_pkg::REG_FLAGS, 32'h0000_003f);
		wr(tca_pkg::REG_PC, 32'h0000_0010);
		wr(tca_pkg::REG_IMM, 32'h0000_0005);
		wr(tca_pkg::REG_CMD, {27'h0, tca_pkg::OP_RELATIVE_JUMP});
		wait_idle();
		rchk("rjump", tca_pkg::REG_PC, 32'h0000_0016);
		wr(tca_pkg::REG_IMM, 32'h0000_0800);
		wr(tca_pkg::REG_CMD, {27'h0, tca_pkg::OP_RELATIVE_JUMP});
		wait_idle();
		rchk("rjump_back", tca_pkg::REG_PC, 32'h0000_f817);
		wr(tca_pkg::REG_ZPTR, 32'h0000_1234);
		wr(tca_pkg::REG_CMD, {27'h0, tca_pkg::OP_Z_POINTER_JUMP});
		wait_idle();
		rchk("zjump", tca_pkg::REG_PC, 32'h0000_1234);
		wr(tca_pkg::REG_ZPTR, 32'h0000_0abc);
		wr(tca_pkg::REG_CMD, {27'h0, tca_pkg::OP_Z_POINTER_CALL});
		wr(tca_pkg::REG_PC, 32'h0000_0555);
		wait_idle();
		rchk("zcall", tca_pkg::REG_PC, 32'h0000_0abc);
		rchk("ret", tca_pkg::REG_RETADR, 32'h0000_1235);
		rchk("stack", tca_pkg::REG_STKPTR, 32'h0000_fffd);
		rchk("jflags", tca_pkg::REG_FLAGS, 32'h0000_003f);
		wr(tca_pkg::REG_PC, 32'h0000_7777, 4'he);
		wr(tca_pkg::REG_STATUS, 32'h0000_0001);
		rchk("pc_sel", tca_pkg::REG_PC, 32'h0000_0abc);
		rchk("status_ro", tca_pkg::REG_STATUS, 32'h0);
	endtask : t_jump

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_byte();
		t_word();
		t_jump();
		end_sim();
	end
endmodule : tca_alu_jumps_tb
